// ===== logic/bridge_window_decode.sv
`timescale 1ns/1ps
`default_nettype none

module bridge_window_decode (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [3:0]                       pstrb,
  output var  logic [31:0]                      prdata,
  output var  logic                             pready,
  output var  logic                             pslverr,
  input  wire window_decode_pkg::decode_req_t   req,
  output var  logic                             fwd_valid,
  output var  logic                             fwd_hit,
  output var  logic                             prefetch_enabled,
  output var  logic                             io_enabled
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the word layouts below assume these carrier widths
  if ($bits(window_decode_pkg::prefetch_regs_t) != 88) begin : g_pf_width_check
    $error("prefetch carrier is not 88 bits wide");
  end
  if ($bits(window_decode_pkg::io_regs_t) != 40) begin : g_io_width_check
    $error("io carrier is not 40 bits wide");
  end
  if ($bits(window_decode_pkg::decode_req_t) != 66) begin : g_req_width_check
    $error("request carrier is not 66 bits wide");
  end
  // each register is one aligned word
  if ((window_decode_pkg::prefetch_window_bounds_offset[1:0] != 2'b00) ||
      (window_decode_pkg::prefetch_lower_bound_high_offset[1:0] != 2'b00) ||
      (window_decode_pkg::prefetch_upper_bound_high_offset[1:0] != 2'b00) ||
      (window_decode_pkg::io_window_high_bits_offset[1:0] != 2'b00) ||
      (window_decode_pkg::io_window_low_bits_offset[1:0] != 2'b00)) begin : g_align_check
    $error("register offsets must be word aligned");
  end
  // start fill must be the complement of end fill
  if ((window_decode_pkg::mem_end_fill != ~window_decode_pkg::mem_start_fill) ||
      (window_decode_pkg::io_end_fill != ~window_decode_pkg::io_start_fill)) begin : g_fill_check
    $error("window fill patterns are not complementary");
  end

  // ****************************************
  // register state
  // ****************************************
  window_decode_pkg::prefetch_regs_t pf;
  window_decode_pkg::prefetch_regs_t next_pf;
  window_decode_pkg::io_regs_t       io;
  window_decode_pkg::io_regs_t       next_io;
  logic [31:0]                       next_prdata;
  logic                              next_pready;
  logic                              next_pslverr;

  logic [31:0] bounds_word;
  logic [31:0] io_high_word;
  logic [31:0] io_low_word;
  logic        wr_en;
  logic        setup;
  logic        mapped;

  // ****************************************
  // byte lane merge
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************
  // read words
  // ****************************************
  always_comb begin
    bounds_word  = {pf.window_end_field, window_decode_pkg::upper_cap_code,
                    pf.window_start_field, window_decode_pkg::upper_cap_code};
    io_high_word = {io.io_end_high, io.io_start_high};
    io_low_word  = {16'h0000, io.io_end_low, 4'h0, io.io_start_low, 4'h0};
  end

  // ****************************************
  // apb slave: one wait-free access phase
  // ****************************************
  always_comb begin
    setup  = psel & ~penable;
    wr_en  = psel & penable & pwrite & pready;
    mapped = (paddr == window_decode_pkg::prefetch_window_bounds_offset) |
             (paddr == window_decode_pkg::prefetch_lower_bound_high_offset) |
             (paddr == window_decode_pkg::prefetch_upper_bound_high_offset) |
             (paddr == window_decode_pkg::io_window_high_bits_offset) |
             (paddr == window_decode_pkg::io_window_low_bits_offset);
  end

  // ****************************************
  // read mux and response
  // ****************************************
  // pready is registered, so every access phase lasts exactly one cycle
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup & ~mapped;
    next_prdata  = 32'h0000_0000;
    if (setup & ~pwrite) begin
      unique case (paddr)
        window_decode_pkg::prefetch_window_bounds_offset:    next_prdata = bounds_word;
        window_decode_pkg::prefetch_lower_bound_high_offset: next_prdata = pf.start_high;
        window_decode_pkg::prefetch_upper_bound_high_offset: next_prdata = pf.end_high;
        window_decode_pkg::io_window_high_bits_offset:       next_prdata = io_high_word;
        window_decode_pkg::io_window_low_bits_offset:        next_prdata = io_low_word;
        default:                                             next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // prefetch register write path
  // ****************************************
  // capability nibbles are dropped here, so they stay read-only
  always_comb begin
    logic [31:0] w;
    w       = 32'h0000_0000;
    next_pf = pf;
    if (wr_en) begin
      unique case (paddr)
        window_decode_pkg::prefetch_window_bounds_offset: begin
          w = merge(bounds_word, pwdata, pstrb);
          next_pf.window_end_field   = w[31:20];
          next_pf.window_start_field = w[15:4];
        end
        window_decode_pkg::prefetch_lower_bound_high_offset: begin
          next_pf.start_high = merge(pf.start_high, pwdata, pstrb);
        end
        window_decode_pkg::prefetch_upper_bound_high_offset: begin
          next_pf.end_high = merge(pf.end_high, pwdata, pstrb);
        end
        default: begin
          w = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // io register write path
  // ****************************************
  // only the two nibbles of the low word are kept, the rest reads zero
  always_comb begin
    logic [31:0] w;
    w       = 32'h0000_0000;
    next_io = io;
    if (wr_en) begin
      unique case (paddr)
        window_decode_pkg::io_window_high_bits_offset: begin
          w = merge(io_high_word, pwdata, pstrb);
          next_io.io_end_high   = w[31:16];
          next_io.io_start_high = w[15:0];
        end
        window_decode_pkg::io_window_low_bits_offset: begin
          w = merge(io_low_word, pwdata, pstrb);
          next_io.io_end_low   = w[15:12];
          next_io.io_start_low = w[7:4];
        end
        default: begin
          w = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // prefetch window registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf.window_end_field   <= window_decode_pkg::prefetch_window_bounds_reset[31:20];
      pf.window_start_field <= window_decode_pkg::prefetch_window_bounds_reset[15:4];
      pf.start_high         <= window_decode_pkg::prefetch_lower_bound_high_reset;
      pf.end_high           <= window_decode_pkg::prefetch_upper_bound_high_reset;
    end else begin
      pf <= next_pf;
    end
  end

  // ****************************************
  // io window registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.io_end_high        <= window_decode_pkg::io_window_high_bits_reset[31:16];
      io.io_start_high      <= window_decode_pkg::io_window_high_bits_reset[15:0];
      io.io_end_low         <= window_decode_pkg::io_window_low_bits_reset[7:4];
      io.io_start_low       <= window_decode_pkg::io_window_low_bits_reset[3:0];
    end else begin
      io <= next_io;
    end
  end

  // ****************************************
  // apb response registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // prefetch window assembly
  // ****************************************
  logic [63:0] pf_start;
  logic [63:0] pf_end;
  logic        pf_on;

  always_comb begin
    pf_start = {pf.start_high, pf.window_start_field, window_decode_pkg::mem_start_fill};
    pf_end   = {pf.end_high, pf.window_end_field, window_decode_pkg::mem_end_fill};
    pf_on    = pf_start <= pf_end;
  end

  // ****************************************
  // io window assembly
  // ****************************************
  logic [31:0] io_start;
  logic [31:0] io_end;
  logic        io_on;

  always_comb begin
    io_start = {io.io_start_high, io.io_start_low, window_decode_pkg::io_start_fill};
    io_end   = {io.io_end_high, io.io_end_low, window_decode_pkg::io_end_fill};
    io_on    = io_start <= io_end;
  end

  // ****************************************
  // request decode
  // ****************************************
  logic        next_fwd_valid;
  logic        next_fwd_hit;
  logic        next_prefetch_enabled;
  logic        next_io_enabled;

  // io space is 32 bits wide, so any upper address bit set is a miss
  always_comb begin
    next_fwd_valid        = req.valid;
    next_fwd_hit          = 1'b0;
    next_prefetch_enabled = pf_on;
    next_io_enabled       = io_on;
    if (req.valid) begin
      if (req.is_io) begin
        next_fwd_hit = io_on & (req.addr[63:32] == 32'h0000_0000) &
                       (req.addr[31:0] >= io_start) & (req.addr[31:0] <= io_end);
      end else begin
        next_fwd_hit = pf_on & (req.addr >= pf_start) & (req.addr <= pf_end);
      end
    end
  end

  // ****************************************
  // decode output registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid        <= 1'b0;
      fwd_hit          <= 1'b0;
      prefetch_enabled <= 1'b0;
      io_enabled       <= 1'b0;
    end else begin
      fwd_valid        <= next_fwd_valid;
      fwd_hit          <= next_fwd_hit;
      prefetch_enabled <= next_prefetch_enabled;
      io_enabled       <= next_io_enabled;
    end
  end

endmodule : bridge_window_decode

`default_nettype wire

// ===== include/window_decode_pkg.sv
package window_decode_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] prefetch_window_bounds_offset    = 12'h024;
  localparam logic [11:0] prefetch_lower_bound_high_offset = 12'h028;
  localparam logic [11:0] prefetch_upper_bound_high_offset = 12'h02C;
  localparam logic [11:0] io_window_high_bits_offset       = 12'h030;
  localparam logic [11:0] io_window_low_bits_offset        = 12'h034;

  // ****************************************
  // reset values and fixed fields
  // ****************************************
  localparam logic [31:0] prefetch_window_bounds_reset    = 32'h0001_0001;
  localparam logic [31:0] prefetch_lower_bound_high_reset = 32'h0000_0000;
  localparam logic [31:0] prefetch_upper_bound_high_reset = 32'h0000_0000;
  localparam logic [31:0] io_window_high_bits_reset       = 32'h0000_0000;
  localparam logic [7:0]  io_window_low_bits_reset        = 8'h00;
  localparam logic [3:0]  upper_cap_code                  = 4'h1;
  localparam logic [19:0] mem_end_fill                    = 20'hF_FFFF;
  localparam logic [19:0] mem_start_fill                  = 20'h0_0000;
  localparam logic [11:0] io_end_fill                     = 12'hFFF;
  localparam logic [11:0] io_start_fill                   = 12'h000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [11:0] window_end_field;
    logic [11:0] window_start_field;
    logic [31:0] start_high;
    logic [31:0] end_high;
  } prefetch_regs_t;

  typedef struct packed {
    logic [15:0] io_end_high;
    logic [15:0] io_start_high;
    logic [3:0]  io_end_low;
    logic [3:0]  io_start_low;
  } io_regs_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [63:0] addr;
  } decode_req_t;

endpackage : window_decode_pkg

// ===== testbench/window_decode_sva.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// decode checker
// *****
module window_decode_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire window_decode_pkg::decode_req_t req,
  input wire logic fwd_valid,
  input wire logic fwd_hit,
  input wire logic prefetch_enabled
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_wzero; pready && pwrite |-> prdata == 32'h0; endproperty
  property p_cap;
    pready && !pwrite && !pslverr && paddr == window_decode_pkg::prefetch_window_bounds_offset
      |-> prdata[19:16] == 4'h1 && prdata[3:0] == 4'h1;
  endproperty
  property p_valid; req.valid |=> fwd_valid; endproperty
  property p_idle; !req.valid |=> !fwd_valid && !fwd_hit; endproperty
  property p_io64; req.valid && req.is_io && req.addr[63:32] != 32'h0 |=> !fwd_hit; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  a_err: assert property (p_err) else $error("error without ready");
  a_wzero: assert property (p_wzero) else $error("read data on write");
  a_cap: assert property (p_cap) else $error("capability code wrong");
  a_valid: assert property (p_valid) else $error("request not forwarded");
  a_idle: assert property (p_idle) else $error("forward without request");
  a_io64: assert property (p_io64) else $error("io hit above 4G");
  c_hit: cover property (fwd_hit);
  c_err: cover property (pslverr);
  c_off: cover property (!prefetch_enabled);
endmodule : window_decode_sva
`default_nettype wire

// ===== testbench/req_source.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// upstream request source
// *****
module req_source (
  input  wire logic                           pclk,
  output var  window_decode_pkg::decode_req_t req
);
  initial req = '0;
  // idle cycles flip the address so stale values never match
  task automatic send(input logic v, input logic io, input logic [63:0] a);
    @(posedge pclk);
    req <= v ? {v, io, a} : {1'b0, io, ~req.addr};
  endtask : send
endmodule : req_source
`default_nettype wire

// ===== testbench/bridge_window_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_window_decode_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, fwd_valid, fwd_hit, pf_en, io_en;
  window_decode_pkg::decode_req_t req;
  int bad_count = 0;
  int checks = 0;
  always #2 pclk = ~pclk;
  req_source src_u (.pclk(pclk), .req(req));
  bridge_window_decode dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req(req), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit),
    .prefetch_enabled(pf_en), .io_enabled(io_en));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t apb transfer timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic probe(input logic io, input logic [63:0] a, input logic hit);
    src_u.send(1'b1, io, a);
    @(posedge pclk);
    #1;
    check({30'h0, fwd_valid, fwd_hit}, {30'h0, 1'b1, hit});
    src_u.send(1'b0, io, a);
  endtask : probe
  task automatic t_reset;
    apb(1'b0, 12'h024, 32'h0);
    check(rd, 32'h0001_0001);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'h028 + 12'(4 * i), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b1, 12'h024, 32'h000F_000E);
    apb(1'b0, 12'h024, 32'h0);
    check(rd, 32'h0001_0001);
    $display("reset test done");
  endtask : t_reset
  task automatic t_mem;
    apb(1'b1, 12'h024, 32'h1230_1000);
    apb(1'b1, 12'h028, 32'h5);
    apb(1'b1, 12'h02C, 32'h5);
    apb(1'b0, 12'h024, 32'h0);
    check(rd, 32'h1231_1001);
    probe(1'b0, 64'h5_1000_0000, 1'b1);
    probe(1'b0, 64'h5_0FFF_FFFF, 1'b0);
    probe(1'b0, 64'h5_123F_FFFF, 1'b1);
    probe(1'b0, 64'h5_1240_0000, 1'b0);
    probe(1'b0, 64'h4_1100_0000, 1'b0);
    probe(1'b0, 64'h6_1100_0000, 1'b0);
    $display("memory window test done");
  endtask : t_mem
  task automatic t_io;
    apb(1'b1, 12'h030, 32'h0002_0001);
    apb(1'b1, 12'h034, 32'h0000_3040);
    probe(1'b1, 64'h1_4000, 1'b1);
    probe(1'b1, 64'h1_3FFF, 1'b0);
    probe(1'b1, 64'h2_3FFF, 1'b1);
    probe(1'b1, 64'h2_4000, 1'b0);
    probe(1'b1, 64'h1_0001_8000, 1'b0);
    check({31'h0, io_en}, 32'h1);
    $display("io window test done");
  endtask : t_io
  task automatic t_off;
    apb(1'b1, 12'h028, 32'h6);
    probe(1'b0, 64'h5_1100_0000, 1'b0);
    probe(1'b0, 64'h6_1100_0000, 1'b0);
    check({31'h0, pf_en}, 32'h0);
    apb(1'b0, 12'h038, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    pstrb <= 4'h1;
    apb(1'b1, 12'h02C, 32'hFFFF_FF07);
    pstrb <= 4'hF;
    apb(1'b0, 12'h02C, 32'h0);
    check(rd, 32'h0000_0007);
    check({31'h0, pf_en}, 32'h1);
    probe(1'b0, 64'h6_1100_0000, 1'b1);
    $display("disabled window test done");
  endtask : t_off
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_mem;
    t_io;
    t_off;
    finish_test;
  end
  initial begin
    #20000;
    bad_count++;
    finish_test;
  end
endmodule : bridge_window_decode_bench
bind bridge_window_decode window_decode_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .req(req), .fwd_valid(fwd_valid), .fwd_hit(fwd_hit),
  .prefetch_enabled(prefetch_enabled));
`default_nettype wire
